// ===== bench/dlp_limit_stop_props.sv
`timescale 1ns/1ps
module dlp_limit_stop_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic [1:0] limit_input_select,
  input wire logic [1:0] limit_stop_method,
  input wire logic [15:0] immediate_stop_torque,
  input wire logic [15:0] motor_speed_abs,
  input wire dlp_pkg::dlp_drive_cmd_t drive_cmd,
  input wire logic err_counter_clear,
  input wire logic err_counter_hold,
  input wire dlp_pkg::dlp_status_t status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_both_open;
    (limit_input_select == 2'h0 && !fwd_limit_in && !rev_limit_in) [*3];
  endsequence
  sequence s_m2_decel;
    (limit_stop_method == 2'h2) [*2] ##0 status.decelerating;
  endsequence
  a_fwd_block: assert property ((limit_input_select == 2'h0 && !fwd_limit_in) [*3] |=> status.fwd_prohibit)
    else $error("fwd not blocked");
  a_rev_block: assert property ((limit_input_select == 2'h0 && !rev_limit_in) [*3] |=> status.rev_prohibit)
    else $error("rev not blocked");
  a_fwd_free: assert property (fwd_limit_in [*3] |=> !status.fwd_prohibit)
    else $error("fwd blocked while closed");
  a_both_alarm: assert property (s_both_open |=> status.alarm && status.alarm_code == 8'h26)
    else $error("no alarm on both open");
  a_any_alarm: assert property ((limit_input_select == 2'h2 && !fwd_limit_in) [*3] |=> status.alarm)
    else $error("no alarm on one open");
  a_off_quiet: assert property ((limit_input_select == 2'h1) [*2] |-> !status.alarm && !status.fwd_prohibit)
    else $error("disabled inputs acted");
  a_m2_cap: assert property (s_m2_decel |-> drive_cmd.torque_limit_en && err_counter_clear)
    else $error("no torque cap");
  a_m2_value: assert property (s_m2_decel |-> drive_cmd.torque_limit == immediate_stop_torque)
    else $error("wrong torque cap");
  a_m0_brake: assert property ((limit_stop_method == 2'h0) [*2] ##0 status.decelerating |-> drive_cmd.dyn_brake)
    else $error("no dynamic brake");
  a_decel_ends: assert property (status.decelerating && motor_speed_abs <= 16'h001e |-> ##[1:3] !status.decelerating)
    else $error("decel did not end");
endmodule
bind dlp_limit_stop dlp_limit_stop_props u_props (.ref_clk, .rst_b, .fwd_limit_in, .rev_limit_in,
  .limit_input_select, .limit_stop_method, .immediate_stop_torque, .motor_speed_abs, .drive_cmd,
  .err_counter_clear, .err_counter_hold, .status);

// ===== bench/dlp_limit_stop_tb_top.sv
`timescale 1ns/1ps
module dlp_limit_stop_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic open_fwd = 1'b0;
  logic open_rev = 1'b0;
  logic fwd_in, rev_in, clr, hold;
  logic [1:0] sel = 2'h0;
  logic [1:0] meth = 2'h0;
  logic [15:0] trq = 16'h0123;
  logic [15:0] spd = 16'h0064;
  dlp_pkg::dlp_drive_cmd_t cmd;
  dlp_pkg::dlp_status_t st;
  int mismatches = 0;
  int cmp_count = 0;
  always #10 ref_clk = ~ref_clk;
  dlp_switch_model sw (.open_fwd(open_fwd), .open_rev(open_rev), .fwd_limit_in(fwd_in), .rev_limit_in(rev_in));
  dlp_limit_stop dut (.ref_clk(ref_clk), .rst_b(rst_b), .fwd_limit_in(fwd_in), .rev_limit_in(rev_in),
    .limit_input_select(sel), .limit_stop_method(meth), .immediate_stop_torque(trq), .motor_speed_abs(spd),
    .drive_cmd(cmd), .err_counter_clear(clr), .err_counter_hold(hold), .status(st));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic w;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic t_stop(input logic [1:0] m);
    @(posedge ref_clk);
    meth <= m;
    spd <= 16'h0064;
    open_fwd <= 1'b1;
    w();
    chk("fwd_prohibit", 16'h1, 16'(st.fwd_prohibit));
    chk("decelerating", 16'h1, 16'(st.decelerating));
    chk("dyn_brake", 16'(m == 2'h0), 16'(cmd.dyn_brake));
    chk("err_hold", 16'(m != 2'h2), 16'(hold));
    chk("err_clear", 16'(m == 2'h2), 16'(clr));
    chk("zero_fwd", 16'(m == 2'h1 || m == 2'h3), 16'(cmd.zero_torque_fwd));
    chk("torque_limit", (m == 2'h2) ? trq : 16'h0000, cmd.torque_limit);
    chk("limit_en", 16'(m == 2'h2), 16'(cmd.torque_limit_en));
    @(posedge ref_clk);
    spd <= 16'h001e;
    w();
    chk("zero_fwd", 16'h1, 16'(cmd.zero_torque_fwd));
    chk("zero_rev", 16'h0, 16'(cmd.zero_torque_rev));
    chk("dyn_brake", 16'h0, 16'(cmd.dyn_brake));
    chk("err_clear", 16'(m == 2'h2), 16'(clr));
    chk("limit_en", 16'h0, 16'(cmd.torque_limit_en));
    @(posedge ref_clk);
    spd <= 16'h0064;
    w();
    chk("stopped", 16'h1, 16'(st.stopped));
    @(posedge ref_clk);
    open_fwd <= 1'b0;
    w();
    chk("fwd_prohibit", 16'h0, 16'(st.fwd_prohibit));
    $display("stop method %0d done", m);
  endtask
  task automatic t_sel;
    @(posedge ref_clk);
    sel <= 2'h2;
    open_fwd <= 1'b1;
    w();
    chk("alarm_code", 16'h0026, {8'h00, st.alarm_code});
    @(posedge ref_clk);
    sel <= 2'h1;
    open_rev <= 1'b1;
    w();
    chk("alarm", 16'h0, 16'(st.alarm));
    @(posedge ref_clk);
    sel <= 2'h0;
    w();
    chk("alarm_code", 16'h0026, {8'h00, st.alarm_code});
    @(posedge ref_clk);
    open_fwd <= 1'b0;
    w();
    chk("rev_prohibit", 16'h1, 16'(st.rev_prohibit));
    chk("fwd_prohibit", 16'h0, 16'(st.fwd_prohibit));
    $display("selection test done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      t_stop(2'(m));
    end
    t_sel();
    tally_and_finish();
  end
endmodule

// ===== bench/dlp_switch_model.sv
`timescale 1ns/1ps
// Switches sit between the inputs and the common return, so closed reads 1 and open reads 0.
module dlp_switch_model (
  input wire logic open_fwd,
  input wire logic open_rev,
  output logic fwd_limit_in,
  output logic rev_limit_in
);
  assign fwd_limit_in = !open_fwd;
  assign rev_limit_in = !open_rev;
endmodule

// ===== logic/dlp_limit_stop.sv
`timescale 1ns/1ps
// Functional notes
// - Selection 1 ignores both limit inputs and never prohibits motion.
// - Selections 0 and 2 monitor both the forward and the reverse limit inputs.
// - With selection 0 a closed forward input is normal and an open one blocks forward motion only.
// - With selection 0 a closed reverse input is normal and an open one blocks reverse motion only.
// - With selection 0 a prohibiting input starts the stop sequence chosen by the stop method.
// - With selection 0 both inputs open together raise alarm 38.
// - With selection 2 either input open raises alarm 38.
// - Stop method 0 brakes dynamically while decelerating, then zero torque that way, error counter held.
// - Stop method 1 gives zero torque that way while decelerating and after, error counter held.
// - Stop method 2 stops immediately then zero torque that way, clearing the error counter throughout.
// - Stop method 2 limits torque during deceleration to the immediate-stop torque value.
// - Deceleration lasts until speed is 30 r/min or less, after which after-stop behaviour holds.
module dlp_limit_stop (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic [1:0] limit_input_select,
  input wire logic [1:0] limit_stop_method,
  input wire logic [dlp_pkg::TORQUE_W-1:0] immediate_stop_torque,
  input wire logic [dlp_pkg::SPEED_W-1:0] motor_speed_abs,
  output dlp_pkg::dlp_drive_cmd_t drive_cmd,
  output logic err_counter_clear,
  output logic err_counter_hold,
  output dlp_pkg::dlp_status_t status
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. A high input means the switch contact is closed.

  logic [1:0] limit_raw;
  logic [1:0] limit_closed;

  assign limit_raw = {rev_limit_in, fwd_limit_in};

  // Channel 0 is the forward input and channel 1 the reverse input.
  for (genvar ch = 0; ch < 2; ch++) begin : g_sync
    logic [1:0] sync_q;

    // Only the second stage is read downstream, so a metastable first stage never fans out.
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_q <= 2'h3;
      end else begin
        sync_q <= {sync_q[0], limit_raw[ch]};
      end
    end

    assign limit_closed[ch] = sync_q[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prohibition and alarm decode.

  logic monitor_en;
  logic fwd_open;
  logic rev_open;
  logic fwd_block;
  logic rev_block;
  logic alarm_now;

  // Reset values assume closed switches so nothing trips before the first samples land.
  assign monitor_en = (limit_input_select == dlp_pkg::SEL_STOP_ONLY) ||
                      (limit_input_select == dlp_pkg::SEL_ALARM_ANY);
  logic [1:0] limit_open;
  logic [1:0] limit_block;
  logic stop_only;

  assign stop_only = limit_input_select == dlp_pkg::SEL_STOP_ONLY;

  // An open input blocks only its own direction, so the axis can back off the switch unless both inputs are open.
  for (genvar ch = 0; ch < 2; ch++) begin : g_block
    assign limit_open[ch] = monitor_en && !limit_closed[ch];
    assign limit_block[ch] = limit_open[ch] && stop_only;
  end

  assign fwd_open = limit_open[0];
  assign rev_open = limit_open[1];
  assign fwd_block = limit_block[0];
  assign rev_block = limit_block[1];
  assign alarm_now = ((limit_input_select == dlp_pkg::SEL_STOP_ONLY) && fwd_open && rev_open) ||
                     ((limit_input_select == dlp_pkg::SEL_ALARM_ANY) && (fwd_open || rev_open));

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequence.

  dlp_pkg::dlp_state_t state_q;
  dlp_pkg::dlp_state_t state_d;
  logic slow;
  logic any_block;

  assign slow = motor_speed_abs <= dlp_pkg::STOP_SPEED;
  assign any_block = fwd_block || rev_block;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dlp_pkg::DLP_RUN: begin
        if (any_block) begin
          state_d = slow ? dlp_pkg::DLP_STOPPED : dlp_pkg::DLP_DECEL;
        end
      end
      dlp_pkg::DLP_DECEL: begin
        if (!any_block) begin
          state_d = dlp_pkg::DLP_RUN;
        end else if (slow) begin
          state_d = dlp_pkg::DLP_STOPPED;
        end
      end
      dlp_pkg::DLP_STOPPED: begin
        // Speed rising again does not re-enter deceleration.
        if (!any_block) begin
          state_d = dlp_pkg::DLP_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= dlp_pkg::DLP_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive commands, registered.

  dlp_pkg::dlp_drive_cmd_t cmd_d;
  logic clear_d;
  logic hold_d;
  logic decel;
  logic stopped;

  assign decel = state_q == dlp_pkg::DLP_DECEL;
  assign stopped = state_q == dlp_pkg::DLP_STOPPED;

  always_comb begin
    cmd_d = '0;
    clear_d = 1'b0;
    hold_d = 1'b0;
    if (decel || stopped) begin
      unique case (limit_stop_method)
        dlp_pkg::STOP_DYN_BRAKE: begin
          cmd_d.dyn_brake = decel;
          cmd_d.zero_torque_fwd = stopped && fwd_block;
          cmd_d.zero_torque_rev = stopped && rev_block;
          hold_d = 1'b1;
        end
        dlp_pkg::STOP_ZERO_TORQUE: begin
          cmd_d.zero_torque_fwd = fwd_block;
          cmd_d.zero_torque_rev = rev_block;
          hold_d = 1'b1;
        end
        dlp_pkg::STOP_IMMEDIATE: begin
          // Immediate stop keeps the servo loop active with a capped torque.
          cmd_d.torque_limit_en = decel;
          cmd_d.torque_limit = decel ? immediate_stop_torque : '0;
          cmd_d.zero_torque_fwd = stopped && fwd_block;
          cmd_d.zero_torque_rev = stopped && rev_block;
          clear_d = 1'b1;
        end
        default: begin
          // Code 3 is out of range; fall back to plain zero torque and hold.
          cmd_d.zero_torque_fwd = fwd_block;
          cmd_d.zero_torque_rev = rev_block;
          hold_d = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive command registers, one for each concern.
  // Every field leaves a flop of its own, so the current loop never sees a decode glitch.

  logic dyn_brake_q;
  logic [1:0] zero_torque_q;
  logic torque_limit_en_q;
  logic [dlp_pkg::TORQUE_W-1:0] torque_limit_q;
  logic err_clear_q;
  logic err_hold_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dyn_brake_q <= 1'b0;
    end else begin
      dyn_brake_q <= cmd_d.dyn_brake;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_torque_q <= 2'h0;
    end else begin
      zero_torque_q <= {cmd_d.zero_torque_rev, cmd_d.zero_torque_fwd};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_limit_en_q <= 1'b0;
    end else begin
      torque_limit_en_q <= cmd_d.torque_limit_en;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_limit_q <= '0;
    end else begin
      torque_limit_q <= cmd_d.torque_limit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_clear_q <= 1'b0;
    end else begin
      err_clear_q <= clear_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_hold_q <= 1'b0;
    end else begin
      err_hold_q <= hold_d;
    end
  end

  assign drive_cmd = '{dyn_brake: dyn_brake_q, zero_torque_fwd: zero_torque_q[0], zero_torque_rev: zero_torque_q[1],
                       torque_limit_en: torque_limit_en_q, torque_limit: torque_limit_q};
  assign err_counter_clear = err_clear_q;
  assign err_counter_hold = err_hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status registers. The alarm follows the inputs; latching is the alarm block's job.

  logic fwd_prohibit_q;
  logic rev_prohibit_q;
  logic decel_q;
  logic stopped_q;
  logic alarm_q;
  logic [7:0] alarm_code_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_prohibit_q <= 1'b0;
    end else begin
      fwd_prohibit_q <= fwd_block;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rev_prohibit_q <= 1'b0;
    end else begin
      rev_prohibit_q <= rev_block;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      decel_q <= 1'b0;
    end else begin
      decel_q <= decel;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stopped_q <= 1'b0;
    end else begin
      stopped_q <= stopped;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_code_q <= 8'h00;
    end else begin
      alarm_code_q <= alarm_now ? dlp_pkg::ALARM_DRIVE_PROHIBIT : 8'h00;
    end
  end

  assign status = '{fwd_prohibit: fwd_prohibit_q, rev_prohibit: rev_prohibit_q, decelerating: decel_q,
                    stopped: stopped_q, alarm: alarm_q, alarm_code: alarm_code_q};

endmodule

// ===== logic/dlp_pkg.sv
package dlp_pkg;

  // Limit input selection codes.
  localparam logic [1:0] SEL_STOP_ONLY = 2'h0;
  localparam logic [1:0] SEL_DISABLED = 2'h1;
  localparam logic [1:0] SEL_ALARM_ANY = 2'h2;
  localparam logic [1:0] SEL_RESET = 2'h1;

  // Limit stop-method codes.
  localparam logic [1:0] STOP_DYN_BRAKE = 2'h0;
  localparam logic [1:0] STOP_ZERO_TORQUE = 2'h1;
  localparam logic [1:0] STOP_IMMEDIATE = 2'h2;
  localparam logic [1:0] STOP_RESET = 2'h0;

  // Alarm number of the drive-prohibition error.
  localparam logic [7:0] ALARM_DRIVE_PROHIBIT = 8'h26;

  // Speed at or below which deceleration counts as finished, in r/min.
  localparam int STOP_SPEED_RPM = 30;
  localparam logic [15:0] STOP_SPEED = 16'(STOP_SPEED_RPM);

  localparam int TORQUE_W = 16;
  localparam int SPEED_W = 16;

  typedef enum logic [1:0] {
    DLP_RUN,
    DLP_DECEL,
    DLP_STOPPED
  } dlp_state_t;

  // Torque shaping commands sent to the current loop.
  typedef struct packed {
    logic dyn_brake;
    logic zero_torque_fwd;
    logic zero_torque_rev;
    logic torque_limit_en;
    logic [TORQUE_W-1:0] torque_limit;
  } dlp_drive_cmd_t;

  // Status seen by the host controller.
  typedef struct packed {
    logic fwd_prohibit;
    logic rev_prohibit;
    logic decelerating;
    logic stopped;
    logic alarm;
    logic [7:0] alarm_code;
  } dlp_status_t;

endpackage
